// >>> bench/sso_host_model.sv
// Host controller model that measures the index pulses it receives
`timescale 1ns/10ps
module sso_host_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       indexIn,
  output logic [7:0]      lastWidth,
  output logic [7:0]      runLength
);
  // Length of the last complete high run on the index line
  always @(posedge core_clk) begin
    if (reset) begin
      runLength <= 8'h00;
      lastWidth <= 8'h00;
    end else if (indexIn) begin
      runLength <= runLength + 8'h01;
    end else if (runLength != 8'h00) begin
      lastWidth <= runLength;
      runLength <= 8'h00;
    end
  end
endmodule : sso_host_model

// >>> bench/tb.sv
// Self-checking bench of the servo status output logic
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic               pol;
    logic signed [15:0] trq;
    logic signed [15:0] spd;
    logic               expT;
    logic               expZ;
  } sso_row_t;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic                   core_clk = 1'b0;
  logic                   reset = 1'b1;
  sso_pkg::sso_settings_t settings;
  sso_pkg::sso_motor_t    motor;
  logic signed [15:0]     commandStep;
  logic                   torqueReachedFlag, zeroSpeedFlag, brakeReleaseOutput, brakePwm;
  logic                   indexOut, serialPortEnable, diffOutP, diffOutN;
  logic signed [15:0]     filteredError, feedforwardOut;
  logic [31:0]            encoderCountMask, encoderAngleOut, pw;
  logic [7:0]             lastWidth;
  int                     fails = 0, n_checks = 0, n;
  sso_row_t rows [8] = '{
    '{1'b0, 16'h0064, 16'h0000, 1'b0, 1'b1}, '{1'b0, 16'h0065, 16'h0007, 1'b1, 1'b1},
    '{1'b0, 16'h0061, 16'h0014, 1'b1, 1'b0}, '{1'b0, 16'h005F, 16'h0007, 1'b0, 1'b0},
    '{1'b0, 16'hFF6A, 16'h0003, 1'b1, 1'b1}, '{1'b1, 16'hFF6A, 16'h0003, 1'b0, 1'b1},
    '{1'b1, 16'h0096, 16'h0003, 1'b1, 1'b1}, '{1'b0, 16'h0000, 16'h0014, 1'b0, 1'b0}};
  logic [15:0] dly [2] = '{16'h0003, 16'h0000};
  logic [6:0]  dutyIn [3] = '{7'h32, 7'h5F, 7'h02};
  logic [6:0]  dutyExp [3] = '{sso_pkg::BRAKE_DUTY_DEF, sso_pkg::BRAKE_DUTY_MAX,
                                sso_pkg::BRAKE_DUTY_MIN};
  logic [7:0]  wIn [3] = '{8'h03, 8'h00, 8'hFA};
  logic [7:0]  wOut [3] = '{8'h03, sso_pkg::INDEX_WIDTH_MIN, sso_pkg::INDEX_WIDTH_MAX};
  logic [5:0]  resIn [4] = '{6'h0A, 6'h20, 6'h28, 6'h05};
  logic [31:0] resOut [4] = '{32'h000003FF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000003FF};

  always #2 core_clk = ~core_clk;

  sso_status_output i_sso_status_output (
    .core_clk(core_clk), .reset(reset), .settings(settings), .motor(motor),
    .commandStep(commandStep), .torqueReachedFlag(torqueReachedFlag),
    .zeroSpeedFlag(zeroSpeedFlag), .brakeReleaseOutput(brakeReleaseOutput),
    .brakePwm(brakePwm), .filteredError(filteredError), .feedforwardOut(feedforwardOut),
    .indexOut(indexOut), .serialPortEnable(serialPortEnable), .diffOutP(diffOutP),
    .diffOutN(diffOutN), .encoderCountMask(encoderCountMask),
    .encoderAngleOut(encoderAngleOut));

  sso_host_model i_sso_host_model (
    .core_clk(core_clk), .reset(reset), .indexIn(indexOut), .lastWidth(lastWidth),
    .runLength());
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    settings = '{sso_pkg::TORQUE_THRESHOLD_DEF, sso_pkg::TORQUE_HYST_DEF, 1'b0,
                 sso_pkg::ZERO_SPEED_DEF, sso_pkg::BRAKE_DELAY_DEF, sso_pkg::BRAKE_DUTY_DEF,
                 1'b0, 7'h00, sso_pkg::FF_TIME_DEF, sso_pkg::INDEX_WIDTH_DEF, 1'b0,
                 sso_pkg::ENC_RES_DEF, 1'b0, sso_pkg::ZERO_OFFSET_DEF};
    motor = '0;
    commandStep = 16'h0000;
    cyc(9);
    chk({torqueReachedFlag, zeroSpeedFlag, brakeReleaseOutput, indexOut}, 32'h0);
    chk({serialPortEnable, encoderCountMask[17:16]}, 32'h5);
    @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      @(posedge core_clk);
      settings.torquePolarity <= rows[i].pol;
      motor.torque <= rows[i].trq;
      motor.speed <= rows[i].spd;
      cyc(3);
      chk(torqueReachedFlag, rows[i].expT);
      chk(zeroSpeedFlag, rows[i].expZ);
    end
    foreach (dly[i]) begin
      @(posedge core_clk);
      settings.brakeDelay <= dly[i];
      motor.energized <= 1'b1;
      n = 0;
      while (brakeReleaseOutput !== 1'b1) begin
        cyc(1);
        n++;
        if (n > 40) begin
          fails++;
          final_report();
        end
      end
      chk(32'(n), 32'(dly[i]) + 32'h2);
      for (int j = 0; j < 3 && i == 1; j++) begin
        @(posedge core_clk);
        settings.brakeDutyMax <= dutyIn[j];
        cyc(100);
        pw = 32'h0;
        repeat (200) begin
          cyc(1);
          pw = pw + 32'(brakePwm);
        end
        chk(pw, 32'(dutyExp[j]) * 32'h2);
      end
      @(posedge core_clk);
      motor.energized <= 1'b0;
      cyc(2);
      chk(brakeReleaseOutput, 32'h0);
    end
    foreach (wIn[i]) begin
      @(posedge core_clk);
      settings.indexPulseWidth <= wIn[i];
      settings.portFunctionSelect <= i[0];
      motor.indexEvent <= 1'b1;
      @(posedge core_clk);
      motor.indexEvent <= 1'b0;
      #1;
      chk({indexOut, serialPortEnable, diffOutP, diffOutN}, {28'h0, 1'b1, ~i[0], i[0], 1'b0});
      cyc(250);
      chk(lastWidth, wOut[i]);
      chk({diffOutP, diffOutN}, {30'h0, 1'b0, i[0]});
    end
    foreach (resIn[i]) begin
      @(posedge core_clk);
      settings.encoderResolution <= resIn[i];
      cyc(3);
      chk(encoderCountMask, resOut[i]);
    end
    @(posedge core_clk);
    motor.encoderAngle <= 32'h000003E8;
    settings.reducedWireEncoder <= 1'b1;
    cyc(3);
    chk(encoderAngleOut, 32'h00000AF0);
    @(posedge core_clk);
    settings.encoderZeroOffset <= 12'hFA0;
    cyc(3);
    chk(encoderAngleOut, 32'h000011F8);
    @(posedge core_clk);
    settings.reducedWireEncoder <= 1'b0;
    cyc(3);
    chk(encoderAngleOut, 32'h000003E8);
    @(posedge core_clk);
    commandStep <= 16'h0064;
    motor.positionError <= 16'h0028;
    cyc(50);
    chk(feedforwardOut, 32'h0);
    chk(filteredError, 32'h00000028);
    @(posedge core_clk);
    settings.feedforwardGain <= 7'h64;
    settings.feedforwardFilterTime <= 16'h0014;
    settings.positionFilterSelect <= 1'b1;
    cyc(1000);
    chk(32'(feedforwardOut >= 16'sh005A && feedforwardOut <= 16'sh0064), 32'h1);
    chk(32'(filteredError >= 16'sh0021 && filteredError <= 16'sh0028), 32'h1);
    // Reset in mid-run clears the filters and restores the default mask
    @(posedge core_clk);
    reset <= 1'b1;
    cyc(2);
    chk({feedforwardOut, filteredError}, 32'h0);
    chk(encoderCountMask, 32'h0001FFFF);
    @(posedge core_clk);
    reset <= 1'b0;
    cyc(2);
    chk(encoderCountMask, 32'h000003FF);
    final_report();
  end
endmodule : tb

// >>> core/sso_pkg.sv
// Package with settings, defaults, field widths and carriers of the servo status output logic
package sso_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned VAL_W   = 16;
  localparam int unsigned PWM_W   = 7;
  // ----------------------------------------------------------------
  // Reset values and ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] TORQUE_THRESHOLD_DEF = 16'h0064;
  localparam logic [15:0] TORQUE_HYST_DEF      = 16'h0005;
  localparam logic [15:0] TORQUE_HYST_MAX      = 16'h012C;
  localparam logic [15:0] ZERO_SPEED_DEF       = 16'h0005;
  localparam logic [15:0] BRAKE_DELAY_DEF      = 16'h0000;
  localparam logic [6:0]  BRAKE_DUTY_MIN       = 7'h05;
  localparam logic [6:0]  BRAKE_DUTY_MAX       = 7'h5A;
  localparam logic [6:0]  BRAKE_DUTY_DEF       = 7'h32;
  localparam logic [6:0]  BRAKE_PERIOD         = 7'h64;
  localparam logic [6:0]  FF_GAIN_MAX          = 7'h64;
  localparam logic [15:0] FF_TIME_MIN          = 16'h0014;
  localparam logic [15:0] FF_TIME_MAX          = 16'h01F4;
  localparam logic [15:0] FF_TIME_DEF          = 16'h0064;
  localparam logic [7:0]  INDEX_WIDTH_MIN      = 8'h01;
  localparam logic [7:0]  INDEX_WIDTH_MAX      = 8'hC8;
  localparam logic [7:0]  INDEX_WIDTH_DEF      = 8'h32;
  localparam logic [5:0]  ENC_RES_MIN          = 6'h0A;
  localparam logic [5:0]  ENC_RES_MAX          = 6'h20;
  localparam logic [5:0]  ENC_RES_DEF          = 6'h11;
  localparam logic [11:0] ZERO_OFFSET_MAX      = 12'hE10;
  localparam logic [11:0] ZERO_OFFSET_DEF      = 12'h708;
  localparam logic [15:0] AVG_LEN              = 16'h0004;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] torqueThreshold;
    logic [15:0] torqueHysteresis;
    logic        torquePolarity;
    logic [15:0] zeroSpeedLevel;
    logic [15:0] brakeDelay;
    logic [6:0]  brakeDutyMax;
    logic        positionFilterSelect;
    logic [6:0]  feedforwardGain;
    logic [15:0] feedforwardFilterTime;
    logic [7:0]  indexPulseWidth;
    logic        portFunctionSelect;
    logic [5:0]  encoderResolution;
    logic        reducedWireEncoder;
    logic [11:0] encoderZeroOffset;
  } sso_settings_t;

  typedef struct packed {
    logic signed [15:0] torque;
    logic signed [15:0] speed;
    logic signed [15:0] positionError;
    logic [31:0]        encoderAngle;
    logic               indexEvent;
    logic               energized;
  } sso_motor_t;

  typedef enum logic [1:0] {
    SSO_BRAKE_HELD,
    SSO_BRAKE_WAIT,
    SSO_BRAKE_OPEN
  } sso_brake_state_t;
endpackage : sso_pkg

// >>> core/sso_status_output.sv
// Status comparators, brake, feedforward, index pulse and port select of the servo drive
`timescale 1ns/10ps
// How it works
// - torqueReachedFlag rises while torque is above the torque threshold (default 100).
// - Torque detection uses hysteresis set by a 0 to 300 percent setting, default 5.
// - Polarity 0 compares torque magnitude, polarity 1 detects positive torque only.
// - zeroSpeedFlag is high while speed is below the zero-speed level, with hysteresis.
// - brakeReleaseOutput rises a set number of cycles after the motor is energized.
// - The brake duty cycle is held between 5 and 90 percent, default 50.
// - Filter select 0 gives a moving-average position filter, 1 an exponential one.
// - The feedforward path is smoothed with a time constant of 20 to 500, default 100.
// - Each index event gives an index pulse of 1 to 200 cycles, default 50.
// - Port select 0 enables the serial port, 1 disables it and drives the index differentially.
// - Encoder resolution is a power-of-two exponent between 10 and 32, default 17.
// - In reduced-wire mode the encoder angle carries a 0 to 3600 zero-point offset.
module sso_status_output (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire sso_pkg::sso_settings_t settings,
  input  wire sso_pkg::sso_motor_t   motor,
  input  wire logic signed [15:0]    commandStep,
  output logic                       torqueReachedFlag,
  output logic                       zeroSpeedFlag,
  output logic                       brakeReleaseOutput,
  output logic                       brakePwm,
  output logic signed [15:0]         filteredError,
  output logic signed [15:0]         feedforwardOut,
  output logic                       indexOut,
  output logic                       serialPortEnable,
  output logic                       diffOutP,
  output logic                       diffOutN,
  output logic [31:0]                encoderCountMask,
  output logic [31:0]                encoderAngleOut
);
  // ----------------------------------------------------------------
  // Setting clamps
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag16

  logic [15:0] hyst;
  logic [6:0]  duty;
  logic [15:0] ffTime;
  logic [7:0]  idxWidth;
  logic [5:0]  encRes;
  logic [6:0]  ffGain;
  logic [11:0] zeroOff;
  always_comb begin
    hyst     = clamp16(settings.torqueHysteresis, 16'h0000, sso_pkg::TORQUE_HYST_MAX);
    duty     = 7'(clamp16({9'h000, settings.brakeDutyMax}, {9'h000, sso_pkg::BRAKE_DUTY_MIN},
                          {9'h000, sso_pkg::BRAKE_DUTY_MAX}));
    ffTime   = clamp16(settings.feedforwardFilterTime, sso_pkg::FF_TIME_MIN,
                       sso_pkg::FF_TIME_MAX);
    idxWidth = 8'(clamp16({8'h00, settings.indexPulseWidth}, {8'h00, sso_pkg::INDEX_WIDTH_MIN},
                          {8'h00, sso_pkg::INDEX_WIDTH_MAX}));
    encRes   = 6'(clamp16({10'h000, settings.encoderResolution}, {10'h000, sso_pkg::ENC_RES_MIN},
                          {10'h000, sso_pkg::ENC_RES_MAX}));
    ffGain   = (settings.feedforwardGain > sso_pkg::FF_GAIN_MAX) ? sso_pkg::FF_GAIN_MAX
               : settings.feedforwardGain;
    zeroOff  = (settings.encoderZeroOffset > sso_pkg::ZERO_OFFSET_MAX) ? sso_pkg::ZERO_OFFSET_MAX
               : settings.encoderZeroOffset;
  end

  // ----------------------------------------------------------------
  // Hysteresis comparators
  // ----------------------------------------------------------------
  logic        next_torqueReachedFlag;
  logic        next_zeroSpeedFlag;
  logic [16:0] torqueVal;
  logic [16:0] speedVal;
  logic [16:0] torqueThr;
  logic [16:0] zeroThr;
  always_comb begin
    // Polarity 1 treats negative torque as zero so only the positive side is seen
    if (settings.torquePolarity) begin
      torqueVal = motor.torque[15] ? 17'h00000 : {1'b0, motor.torque};
    end else begin
      torqueVal = {1'b0, mag16(motor.torque)};
    end
    speedVal  = {1'b0, mag16(motor.speed)};
    torqueThr = {1'b0, settings.torqueThreshold};
    zeroThr   = {1'b0, settings.zeroSpeedLevel};
    next_torqueReachedFlag = torqueReachedFlag;
    if (!torqueReachedFlag && torqueVal > torqueThr) begin
      next_torqueReachedFlag = 1'b1;
    end else if (torqueReachedFlag && torqueVal + {1'b0, hyst} <= torqueThr) begin
      next_torqueReachedFlag = 1'b0;
    end
    next_zeroSpeedFlag = zeroSpeedFlag;
    if (!zeroSpeedFlag && speedVal < zeroThr) begin
      next_zeroSpeedFlag = 1'b1;
    end else if (zeroSpeedFlag && speedVal >= zeroThr + 17'(sso_pkg::ZERO_SPEED_DEF)) begin
      next_zeroSpeedFlag = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      torqueReachedFlag <= 1'b0;
      zeroSpeedFlag     <= 1'b0;
    end else begin
      torqueReachedFlag <= next_torqueReachedFlag;
      zeroSpeedFlag     <= next_zeroSpeedFlag;
    end
  end

  // ----------------------------------------------------------------
  // Brake release and duty limit
  // ----------------------------------------------------------------
  sso_pkg::sso_brake_state_t brakeState, next_brakeState;
  logic [15:0] brakeCount, next_brakeCount;
  logic        next_brakeReleaseOutput;
  logic [6:0]  pwmCount, next_pwmCount;
  logic        next_brakePwm;
  always_comb begin
    next_brakeState = brakeState;
    next_brakeCount = brakeCount;
    unique case (brakeState)
      sso_pkg::SSO_BRAKE_HELD: begin
        next_brakeCount = 16'h0000;
        if (motor.energized) begin
          next_brakeState = sso_pkg::SSO_BRAKE_WAIT;
        end
      end
      sso_pkg::SSO_BRAKE_WAIT: begin
        if (!motor.energized) begin
          next_brakeState = sso_pkg::SSO_BRAKE_HELD;
        end else if (brakeCount >= settings.brakeDelay) begin
          next_brakeState = sso_pkg::SSO_BRAKE_OPEN;
        end else begin
          next_brakeCount = brakeCount + 16'h0001;
        end
      end
      sso_pkg::SSO_BRAKE_OPEN: begin
        if (!motor.energized) begin
          next_brakeState = sso_pkg::SSO_BRAKE_HELD;
        end
      end
      default: next_brakeState = sso_pkg::SSO_BRAKE_HELD;
    endcase
    next_brakeReleaseOutput = (next_brakeState == sso_pkg::SSO_BRAKE_OPEN);
    next_pwmCount = (pwmCount == sso_pkg::BRAKE_PERIOD - 7'h01) ? 7'h00 : pwmCount + 7'h01;
    // Coil drive only while released, high for duty out of each hundred cycles
    next_brakePwm = next_brakeReleaseOutput && (next_pwmCount < duty);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      brakeState         <= sso_pkg::SSO_BRAKE_HELD;
      brakeCount         <= 16'h0000;
      brakeReleaseOutput <= 1'b0;
      pwmCount           <= 7'h00;
      brakePwm           <= 1'b0;
    end else begin
      brakeState         <= next_brakeState;
      brakeCount         <= next_brakeCount;
      brakeReleaseOutput <= next_brakeReleaseOutput;
      pwmCount           <= next_pwmCount;
      brakePwm           <= next_brakePwm;
    end
  end

  // ----------------------------------------------------------------
  // Position filter and feedforward
  // ----------------------------------------------------------------
  logic signed [15:0] avgTap [4];
  logic signed [15:0] next_avgTap [4];
  logic signed [17:0] avgSum;
  logic signed [15:0] expState, next_expState;
  logic signed [15:0] next_filteredError;
  logic signed [31:0] ffRaw, ffAcc, next_ffAcc;
  logic signed [15:0] next_feedforwardOut;
  always_comb begin
    next_avgTap[0] = motor.positionError;
    avgSum = 18'(motor.positionError);
    for (int i = 1; i < 4; i++) begin
      next_avgTap[i] = avgTap[i-1];
      avgSum = avgSum + 18'(avgTap[i-1]);
    end
    next_expState = expState + ((motor.positionError - expState) >>> 3);
    next_filteredError = settings.positionFilterSelect ? next_expState
                         : 16'(avgSum >>> 2);
    ffRaw = (32'(commandStep) * $signed({25'h0000000, ffGain})) / 32'sd100;
    // First-order lag, ffAcc scaled by ffTime
    next_ffAcc = ffAcc + ffRaw - ffAcc / $signed({16'h0000, ffTime});
    next_feedforwardOut = 16'(next_ffAcc / $signed({16'h0000, ffTime}));
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        avgTap[i] <= 16'sh0000;
      end
      expState       <= 16'sh0000;
      filteredError  <= 16'sh0000;
      ffAcc          <= 32'sh00000000;
      feedforwardOut <= 16'sh0000;
    end else begin
      avgTap         <= next_avgTap;
      expState       <= next_expState;
      filteredError  <= next_filteredError;
      ffAcc          <= next_ffAcc;
      feedforwardOut <= next_feedforwardOut;
    end
  end

  // ----------------------------------------------------------------
  // Index pulse, port select and encoder
  // ----------------------------------------------------------------
  logic [7:0]  idxCount, next_idxCount;
  logic        next_indexOut;
  logic [31:0] next_encoderCountMask;
  logic [31:0] next_encoderAngleOut;
  logic        next_serialPortEnable;
  logic        next_diffOutP;
  logic        next_diffOutN;
  always_comb begin
    next_idxCount = (idxCount != 8'h00) ? idxCount - 8'h01 : 8'h00;
    if (motor.indexEvent) begin
      next_idxCount = idxWidth;
    end
    next_indexOut = (next_idxCount != 8'h00);
    next_serialPortEnable = !settings.portFunctionSelect;
    next_diffOutP = settings.portFunctionSelect && next_indexOut;
    next_diffOutN = settings.portFunctionSelect && !next_indexOut;
    next_encoderCountMask = (encRes >= 6'h20) ? 32'hFFFFFFFF
                            : 32'((33'h000000001 << encRes) - 33'h000000001);
    next_encoderAngleOut = settings.reducedWireEncoder ? motor.encoderAngle + {20'h00000, zeroOff}
                           : motor.encoderAngle;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      idxCount         <= 8'h00;
      indexOut         <= 1'b0;
      serialPortEnable <= 1'b1;
      diffOutP         <= 1'b0;
      diffOutN         <= 1'b0;
      encoderCountMask <= 32'h0001FFFF;
      encoderAngleOut  <= 32'h00000000;
    end else begin
      idxCount         <= next_idxCount;
      indexOut         <= next_indexOut;
      serialPortEnable <= next_serialPortEnable;
      diffOutP         <= next_diffOutP;
      diffOutN         <= next_diffOutN;
      encoderCountMask <= next_encoderCountMask;
      encoderAngleOut  <= next_encoderAngleOut;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  torque_set_a: assert property (@(posedge core_clk) disable iff (reset)
    !torqueReachedFlag && torqueVal > torqueThr |=> torqueReachedFlag)
    else $error("torque flag did not set");
  torque_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    torqueReachedFlag && torqueVal + {1'b0, hyst} > torqueThr |=> torqueReachedFlag)
    else $error("torque flag dropped inside hysteresis");
  zero_speed_a: assert property (@(posedge core_clk) disable iff (reset)
    !zeroSpeedFlag && speedVal < zeroThr |=> zeroSpeedFlag)
    else $error("zero speed flag did not set");
  brake_early_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(brakeReleaseOutput) |-> $past(motor.energized))
    else $error("brake released without energy");
  brake_duty_a: assert property (@(posedge core_clk) disable iff (reset)
    !brakeReleaseOutput |-> !brakePwm)
    else $error("brake pwm while held");
  index_width_a: assert property (@(posedge core_clk) disable iff (reset)
    motor.indexEvent |=> indexOut)
    else $error("index pulse missing");
  port_select_a: assert property (@(posedge core_clk) disable iff (reset)
    serialPortEnable |-> !diffOutP && !diffOutN)
    else $error("differential output active with serial port");
  pol_neg_a: assert property (@(posedge core_clk) disable iff (reset)
    settings.torquePolarity && motor.torque[15] && !torqueReachedFlag |=> !torqueReachedFlag)
    else $error("negative torque detected in positive mode");
  torque_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    torqueReachedFlag && torqueVal + {1'b0, hyst} <= torqueThr |=> !torqueReachedFlag)
    else $error("torque flag stayed past hysteresis");
  zero_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    zeroSpeedFlag && speedVal < zeroThr + 17'(sso_pkg::ZERO_SPEED_DEF) |=> zeroSpeedFlag)
    else $error("zero speed flag dropped inside hysteresis");
  brake_wait_a: assert property (@(posedge core_clk) disable iff (reset)
    brakeState == sso_pkg::SSO_BRAKE_WAIT && brakeCount < settings.brakeDelay
    |=> !brakeReleaseOutput)
    else $error("brake released before delay");
  index_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    indexOut && idxCount > 8'h01 |=> indexOut)
    else $error("index pulse ended early");
  diff_pair_a: assert property (@(posedge core_clk) disable iff (reset)
    !serialPortEnable |-> diffOutP != diffOutN)
    else $error("differential pair not complementary");
  mask_floor_a: assert property (@(posedge core_clk) disable iff (reset)
    encoderCountMask[9:0] == 10'h3FF)
    else $error("encoder mask below minimum resolution");
endmodule : sso_status_output
